// ### rtl/cou_defs.svh
// Offsets, field positions, reset values and timing counts of the option byte and the charge registers.
`ifndef COU_DEFS_SVH
`define COU_DEFS_SVH
`define COU_OFS_OPT_HI      8'h01
`define COU_OFS_OPT_LO      8'h00
`define COU_OFS_CHG_CUR_LO  8'h02
`define COU_OFS_CHG_CUR_HI  8'h03
`define COU_OFS_CHG_VOL_LO  8'h04
`define COU_OFS_CHG_VOL_HI  8'h05
`define COU_BIT_LOW_POWER   7
`define COU_BIT_WDT_HI      6
`define COU_BIT_WDT_LO      5
`define COU_BIT_AUTO_OFF    4
`define COU_BIT_OTG_CHGOK   3
`define COU_BIT_OOA         2
`define COU_BIT_FREQ        1
`define COU_BIT_RSVD        0
`define COU_BIT_IREG_EN     1
`define COU_OPT_HI_RESET    8'hE2
`define COU_IREG_EN_RESET   1'b1
`define COU_WDT_OFF         2'h0
`define COU_WDT_5S          2'h1
`define COU_WDT_88S         2'h2
`define COU_WDT_175S        2'h3
`define COU_CLK_HZ          10000000
`define COU_WDT_5S_SEC      5
`define COU_WDT_88S_SEC     88
`define COU_WDT_175S_SEC    175
`define COU_TICK_SEC        1
`define COU_TICK_CYC        (`COU_CLK_HZ * `COU_TICK_SEC)
`define COU_FREQ_1200K_KHZ  1200
`define COU_FREQ_800K_KHZ   800
`define COU_OOA_MIN_KHZ     25
`endif

// ### rtl/cou_pkg.sv
// Types shared by the option byte control logic.
package cou_pkg;
  typedef struct packed {
    logic       lowPower;
    logic [1:0] watchdogPeriodSel;
    logic       inputRegAutoOff;
    logic       otgFlagsChargeGood;
    logic       outOfAudioEnable;
    logic       switchingFreqSel;
    logic       reserved0;
  } cou_opt_s;

  typedef enum logic [1:0] {
    COU_WD_IDLE    = 2'b01,
    COU_WD_EXPIRED = 2'b10
  } cou_wd_e;

  typedef struct packed {
    logic   valid;
    logic   write;
    logic [7:0] addr;
    logic [7:0] wdata;
  } cou_req_s;
endpackage : cou_pkg

// ### rtl/cou_option_upper.sv
// Upper option byte: watchdog, auto-off, charge-good, burst and frequency.
`timescale 1ns/1ps
`default_nettype none
`include "cou_defs.svh"
module cou_option_upper
  import cou_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = `COU_TICK_CYC
) (
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire cou_req_s   req,
  input  wire logic       batteryPresentPin,
  input  wire logic       otgMode,
  output var  logic [7:0] rdata,
  output var  logic       inputCurrentRegEnable,
  output var  logic       chargeGoodOut,
  output var  logic       chargeGoodSrc,
  output var  logic       chargeSuspend,
  output var  logic       outOfAudioEnable,
  output var  logic       switchingFreqSel,
  output var  logic       watchdogRunning
);
  // Watchdog limits in whole seconds, as the seconds counter compares them.
  localparam logic [7:0] LIMIT5   = 8'(`COU_WDT_5S_SEC);
  localparam logic [7:0] LIMIT88  = 8'(`COU_WDT_88S_SEC);
  localparam logic [7:0] LIMIT175 = 8'(`COU_WDT_175S_SEC);

  initial begin
    if (TICK_CYCLES < 2) begin
      $error("TICK_CYCLES must be at least 2");
    end
    if (`COU_WDT_175S_SEC > 255) begin
      $error("Longest watchdog period does not fit the seconds counter");
    end
    if (LIMIT5 == 8'h00) begin
      $error("Shortest watchdog period must be at least one second");
    end
    if (LIMIT5 >= LIMIT88 || LIMIT88 >= LIMIT175) begin
      $error("Watchdog periods must rise with the select code");
    end
  end

  typedef struct packed {
    cou_opt_s   opt;
    logic       iregEn;
    logic [1:0] batSync;
    cou_wd_e    wdState;
    logic [31:0] tickCnt;
    logic [7:0] secCnt;
    logic       suspend;
    logic [7:0] rdata;
    logic       chargeGood;
    logic       wdRun;
  } cou_state_s;

  cou_state_s state_r;
  cou_state_s state_nxt;

  function automatic logic [7:0] wdLimit(input logic [1:0] sel);
    unique case (sel)
      `COU_WDT_5S:   wdLimit = LIMIT5;
      `COU_WDT_88S:  wdLimit = LIMIT88;
      `COU_WDT_175S: wdLimit = LIMIT175;
      default:       wdLimit = 8'h00;
    endcase
  endfunction

  always_comb begin
    logic wrHi;
    logic wrLo;
    logic wrChg;
    logic kick;
    logic wdOn;
    wrHi  = req.valid && req.write && req.addr == `COU_OFS_OPT_HI;
    wrLo  = req.valid && req.write && req.addr == `COU_OFS_OPT_LO;
    wrChg = req.valid && req.write &&
            (req.addr == `COU_OFS_CHG_CUR_LO ||
             req.addr == `COU_OFS_CHG_CUR_HI ||
             req.addr == `COU_OFS_CHG_VOL_LO ||
             req.addr == `COU_OFS_CHG_VOL_HI);
    kick  = wrChg || wrHi;
    state_nxt = state_r;
    // The first stage is read only by the second to avoid metastability.
    state_nxt.batSync = {state_r.batSync[0], batteryPresentPin};

    // Field by field, so a moved bit is one changed define and not a rewire.
    if (wrHi) begin
      state_nxt.opt.lowPower           = req.wdata[`COU_BIT_LOW_POWER];
      state_nxt.opt.watchdogPeriodSel  =
        req.wdata[`COU_BIT_WDT_HI:`COU_BIT_WDT_LO];
      state_nxt.opt.inputRegAutoOff    = req.wdata[`COU_BIT_AUTO_OFF];
      state_nxt.opt.otgFlagsChargeGood = req.wdata[`COU_BIT_OTG_CHGOK];
      state_nxt.opt.outOfAudioEnable   = req.wdata[`COU_BIT_OOA];
      state_nxt.opt.switchingFreqSel   = req.wdata[`COU_BIT_FREQ];
      state_nxt.opt.reserved0          = req.wdata[`COU_BIT_RSVD];
    end

    if (wrLo) begin
      state_nxt.iregEn = req.wdata[`COU_BIT_IREG_EN];
    end
    // Hardware clear wins over a host write in the same cycle.
    if (state_r.opt.inputRegAutoOff && !state_r.batSync[1]) begin
      state_nxt.iregEn = 1'b0;
    end
    wdOn = state_nxt.opt.watchdogPeriodSel != `COU_WDT_OFF;
    if (kick || !wdOn) begin
      state_nxt.tickCnt = 32'h0;
      state_nxt.secCnt  = 8'h00;
      state_nxt.wdState = COU_WD_IDLE;
      state_nxt.suspend = 1'b0;
    end else begin
      unique case (state_r.wdState)
        COU_WD_IDLE: begin
          if (state_r.tickCnt == 32'(TICK_CYCLES - 1)) begin
            state_nxt.tickCnt = 32'h0;
            state_nxt.secCnt  = state_r.secCnt + 8'h01;
            if (state_r.secCnt + 8'h01 >=
                wdLimit(state_r.opt.watchdogPeriodSel)) begin
              state_nxt.wdState = COU_WD_EXPIRED;
              state_nxt.suspend = 1'b1;
            end
          end else begin
            state_nxt.tickCnt = state_r.tickCnt + 32'h1;
          end
        end
        COU_WD_EXPIRED: begin
          state_nxt.suspend = 1'b1;
        end
      endcase
    end

    // Registered so that the pin shows no decode glitch between states.
    state_nxt.wdRun = state_nxt.wdState == COU_WD_IDLE && wdOn;

    state_nxt.chargeGood = state_r.opt.otgFlagsChargeGood && otgMode;

    // The answer stands for one cycle and returns to zero afterwards.
    state_nxt.rdata = 8'h00;
    if (req.valid && !req.write) begin
      unique case (req.addr)
        `COU_OFS_OPT_HI: begin
          state_nxt.rdata[`COU_BIT_LOW_POWER] = state_r.opt.lowPower;
          state_nxt.rdata[`COU_BIT_WDT_HI:`COU_BIT_WDT_LO] =
            state_r.opt.watchdogPeriodSel;
          state_nxt.rdata[`COU_BIT_AUTO_OFF]  = state_r.opt.inputRegAutoOff;
          state_nxt.rdata[`COU_BIT_OTG_CHGOK] = state_r.opt.otgFlagsChargeGood;
          state_nxt.rdata[`COU_BIT_OOA]       = state_r.opt.outOfAudioEnable;
          state_nxt.rdata[`COU_BIT_FREQ]      = state_r.opt.switchingFreqSel;
          state_nxt.rdata[`COU_BIT_RSVD]      = state_r.opt.reserved0;
        end
        `COU_OFS_OPT_LO: begin
          state_nxt.rdata[`COU_BIT_IREG_EN] = state_r.iregEn;
        end
        default: begin
          state_nxt.rdata = 8'h00;
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_r            <= '0;
      state_r.opt        <= cou_opt_s'(`COU_OPT_HI_RESET);
      state_r.iregEn     <= `COU_IREG_EN_RESET;
      state_r.batSync    <= 2'b11;
      state_r.wdState    <= COU_WD_IDLE;
      state_r.wdRun      <= 1'b1;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign rdata                 = state_r.rdata;
  assign inputCurrentRegEnable = state_r.iregEn;
  assign chargeGoodOut         = state_r.chargeGood;
  assign chargeGoodSrc         = state_r.chargeGood;
  assign chargeSuspend         = state_r.suspend;
  assign outOfAudioEnable      = state_r.opt.outOfAudioEnable;
  assign switchingFreqSel      = state_r.opt.switchingFreqSel;
  assign watchdogRunning       = state_r.wdRun;
endmodule : cou_option_upper
`default_nettype wire

// ### bench/cou_chk.sv
// Checker for the upper option byte.
`timescale 1ns/1ps
`default_nettype none
module cou_chk
  import cou_pkg::*;
(
  input wire logic       clk,
  input wire logic       reset,
  input wire cou_req_s   req,
  input wire logic       batteryPresentPin,
  input wire logic       otgMode,
  input wire logic [7:0] rdata,
  input wire logic       inputCurrentRegEnable,
  input wire logic       chargeGoodOut,
  input wire logic       chargeGoodSrc,
  input wire logic       chargeSuspend,
  input wire logic       outOfAudioEnable,
  input wire logic       switchingFreqSel,
  input wire logic       watchdogRunning
);
  logic [7:0] optR;
  logic       cg;
  logic       wr;
  assign wr = req.valid && req.write;
  assign cg = optR[3] && otgMode;
  // Own copy of the byte, so outputs are judged without looking inside.
  always_ff @(posedge clk or posedge reset)
    if (reset) optR <= 8'hE2;
    else if (wr && req.addr == 8'h01) optR <= req.wdata;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  a_freq_sel: assert property (switchingFreqSel == optR[1])
    else $error("freq");
  a_burst_floor: assert property (outOfAudioEnable == optR[2])
    else $error("burst");
  a_chg_good: assert property (1 |=> chargeGoodOut == $past(cg))
    else $error("good");
  a_good_copy: assert property (chargeGoodSrc == chargeGoodOut)
    else $error("copy");
  a_auto_off: assert property ((optR[4] && !batteryPresentPin) [*4] |->
    !inputCurrentRegEnable) else $error("auto");
  a_keep_en: assert property (!optR[4] && inputCurrentRegEnable &&
    !(wr && req.addr == 8'h00) |=> inputCurrentRegEnable) else $error("en");
  a_read_back: assert property (req.valid && !req.write &&
    req.addr == 8'h01 |=> rdata == optR) else $error("read");
  a_wdt_off: assert property (wr && req.addr == 8'h01 &&
    req.wdata[6:5] == 2'h0 |=> !watchdogRunning && !chargeSuspend)
    else $error("wdt");
  c_auto: cover property (optR[4] && !batteryPresentPin ##4 !inputCurrentRegEnable);
  c_exp: cover property ($rose(chargeSuspend));
  c_good: cover property (chargeGoodOut && otgMode);
endmodule : cou_chk
bind cou_option_upper cou_chk u_chk (.*);
`default_nettype wire

// ### bench/cou_host.sv
// Host controller model issuing one-byte register accesses.
`timescale 1ns/1ps
`default_nettype none
module cou_host
  import cou_pkg::*;
(
  input  wire logic       clk,
  input  wire logic [7:0] rdata,
  output var  cou_req_s   req
);
  logic [7:0] q;
  initial req = '0;
  task automatic acc(input logic w, input logic [7:0] a, d);
    @(posedge clk);
    #1 req <= '{1'b1, w, a, d};
    @(posedge clk);
    #1 q = rdata;
    req.valid <= 1'b0;
  endtask : acc
endmodule : cou_host
`default_nettype wire

// ### bench/tb.sv
// Self-checking bench for the upper option byte.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) begin check_count++; if ((a) !== (e)) begin \
  n_fail++; $display("ERROR %s exp %h got %h", n, e, a); end end
module tb;
  localparam int TICK = 10;
  logic clk = 0, reset = 1, pin = 1, otg = 0;
  logic [7:0] rdata;
  logic iEn, cgOut, susp, ooa, freq, wdRun;
  cou_pkg::cou_req_s req;
  int n_fail = 0, check_count = 0;
  logic [31:0] seed = 32'hDB9626B6;
  always #50 clk = ~clk;
  cou_host HOST (.clk(clk), .rdata(rdata), .req(req));
  cou_option_upper #(.TICK_CYCLES(TICK)) DUT (.clk(clk), .reset(reset),
    .req(req), .batteryPresentPin(pin), .otgMode(otg), .rdata(rdata),
    .inputCurrentRegEnable(iEn), .chargeGoodOut(cgOut), .chargeGoodSrc(),
    .chargeSuspend(susp), .outOfAudioEnable(ooa), .switchingFreqSel(freq),
    .watchdogRunning(wdRun));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  function automatic int wdCyc(input logic [1:0] c);
    return TICK * ((c == 2'h1) ? 5 : (c == 2'h2) ? 88 : 175);
  endfunction : wdCyc
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  task automatic conclude();
    $display("checks %0d failures %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : conclude
  initial begin
    #1000000;
    n_fail++;
    conclude();
  end
  initial begin
    logic [7:0] d;
    tick(2);
    reset = 0;
    HOST.acc(0, 8'h01, 8'h00);
    `CHK("opt", 8'hE2, HOST.q)
    HOST.acc(0, 8'h00, 8'h00);
    `CHK("lo", 8'h02, HOST.q)
    `CHK("run", 1'b1, wdRun)
    $display("reset test done");
    repeat (24) begin
      d = 8'(rnd());
      otg = 1'(rnd());
      HOST.acc(1, 8'h01, d);
      tick(1);
      `CHK("freq", d[1], freq)
      `CHK("ooa", d[2], ooa)
      `CHK("good", d[3] & otg, cgOut)
      HOST.acc(0, 8'h01, 8'h00);
      `CHK("back", d, HOST.q)
    end
    $display("random test done");
    HOST.acc(1, 8'h01, 8'h10);
    pin = 0;
    tick(4);
    `CHK("off", 1'b0, iEn)
    HOST.acc(0, 8'h00, 8'h00);
    `CHK("lo", 8'h00, HOST.q)
    pin = 1;
    tick(3);
    HOST.acc(1, 8'h00, 8'h02);
    `CHK("on", 1'b1, iEn)
    HOST.acc(1, 8'h01, 8'h00);
    pin = 0;
    tick(4);
    `CHK("keep", 1'b1, iEn)
    pin = 1;
    $display("auto-off test done");
    for (int c = 1; c < 4; c++) begin
      HOST.acc(1, 8'h01, {1'b0, c[1:0], 5'h00});
      tick(wdCyc(c[1:0]) - 10);
      `CHK("early", 1'b0, susp)
      tick(15);
      `CHK("expire", 1'b1, susp)
      HOST.acc(1, 8'h03, 8'h00);
      `CHK("kick", 1'b0, susp)
    end
    HOST.acc(1, 8'h01, 8'h00);
    tick(1800);
    `CHK("off", 2'b00, {susp, wdRun})
    $display("watchdog test done");
    conclude();
  end
endmodule : tb
`default_nettype wire
